// >>> sim/tfs_host_model.sv
// host bus adapter model: parity-guarded data words and the run signal
// assumes the bench drives its requests off the clock edge
`timescale 1ns/1ps
module tfs_host_model (
	input  wire logic        clk_in,
	input  wire logic        send_in,
	input  wire logic        bad_par_in,
	input  wire logic [15:0] word_in,
	input  wire logic        run_req_in,
	output logic             strobe_out,
	output logic [15:0]      data_out,
	output logic             parity_out,
	output logic             run_out
);
	initial
	begin
		strobe_out = 1'b0;
		data_out = 16'h0000;
		parity_out = 1'b1;
		run_out = 1'b0;
	end
	always @(posedge clk_in)
	begin
		strobe_out <= send_in;
		if (send_in)
		begin
			data_out <= word_in;
			parity_out <= ~^word_in ^ bad_par_in;
		end
		else
		begin
			// released bus must not keep looking valid
			data_out <= ~data_out;
			parity_out <= ~parity_out;
		end
		run_out <= run_req_in;
	end
endmodule // tfs_host_model

// >>> sim/tfs_status_gen_asserts.sv
// port checker of the non-data status generator
// assumes binding to tfs_status_gen, one clock domain
`timescale 1ns/1ps
module tfs_status_gen_asserts
	import tfs_pkg::*;
#(
	parameter int RUN_WAIT_CYC = 8
) (
	input wire logic        mclk_in,
	input wire logic        reset_n_in,
	input wire logic [5:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        op_end_in,
	input wire tfs_event_s  event_in,
	input wire tfs_xport_s  xport_in,
	input wire tfs_fault_s  fault_in,
	input wire logic        loop_check_in,
	input wire logic [7:0]  loop_loaded_in,
	input wire logic [7:0]  loop_readback_in,
	input wire logic [2:0]  loop_step_in,
	input wire logic [15:0] status_word_out,
	input wire logic        status_valid_out,
	input wire logic        op_refused_out,
	input wire logic        data_invalid_out,
	input wire logic        fatal_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	// no fault pulse and no loop check may pre-empt the one watched
	logic quiet;
	assign quiet = (fault_in == '0) && !loop_check_in;

	a_word_spare: assert property (status_valid_out |-> status_word_out[7:6] == 2'b00
		&& status_word_out[5:0] != 6'o00) else $error("status word layout wrong");
	a_fatal_refuse: assert property (op_end_in && fatal_out && quiet |=> op_refused_out
		&& status_word_out[15:10] == 6'o02 && status_word_out[5:0] == 6'o11) else $error("fatal op not refused");
	a_absent_code: assert property (op_end_in && !fatal_out && !xport_in.present && quiet
		|=> op_refused_out && status_word_out[5:0] == 6'o14) else $error("absent transport code wrong");
	a_offline_code: assert property (op_end_in && !fatal_out && xport_in.present && !xport_in.online
		&& quiet |=> status_word_out[5:0] == 6'o13) else $error("offline code wrong");
	a_inv_cmd: assert property (fault_in.inv_cmd |=> status_valid_out && fatal_out
		&& status_word_out[15:10] == 6'o01 && status_word_out[5:0] == 6'o30) else $error("invalid command fault wrong");
	a_clear_fatal: assert property (reg_wr_in && reg_addr_in == 6'h00 && reg_wdata_in[14] && quiet
		|=> !fatal_out) else $error("formatter clear ignored");
	a_xport_num: assert property (op_end_in && quiet |=> status_valid_out
		&& status_word_out[9:8] == $past(event_in.xport_num)) else $error("transport number wrong");
	a_rec_len: assert property (data_invalid_out |-> status_valid_out
		&& status_word_out[15:10] == 6'o13 && status_word_out[5:0] == 6'o27) else $error("invalid data flag wrong");
	a_loop_step: assert property (loop_check_in && loop_loaded_in != loop_readback_in && loop_step_in <= 3'h5
		&& fault_in == '0 |-> ##2 status_valid_out && status_word_out[15:10] == 6'o10 + $past(loop_step_in, 2))
		else $error("loopback fault subcode wrong");
	a_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000) else $error("read data not idle");

	c_fatal: cover property (op_end_in && fatal_out);
	c_invalid: cover property (data_invalid_out);
	c_loop: cover property (loop_check_in && loop_loaded_in != loop_readback_in);
endmodule // tfs_status_gen_asserts

bind tfs_status_gen tfs_status_gen_asserts #(.RUN_WAIT_CYC(RUN_WAIT_CYC)) u_chk (.*);

// >>> sim/tfs_status_gen_test.sv
// self-checking bench of the non-data status generator
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
module tfs_status_gen_test;
	import tfs_pkg::*;
	logic mclk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, op_end_in = 0, xfer_start_in = 0;
	logic loop_check_in = 0, send = 0, bad = 0, run_req = 0, strobe, parity, run, valid, refused, invalid, fatal;
	logic [5:0] reg_addr_in = 0;
	logic [15:0] reg_wdata_in = 0, wd = 0, hdata, rdata, word, d;
	logic [7:0] loaded = 0, readback = 0;
	logic [2:0] step = 0;
	tfs_event_s event_in = '0, e;
	tfs_xport_s xport_in = '0, ok;
	tfs_fault_s fault_in = '0;
	int errors = 0, total_checks = 0;

	always #10 mclk_in = ~mclk_in;

	tfs_status_gen #(.RUN_WAIT_CYC(8)) DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(rdata), .op_end_in(op_end_in), .event_in(event_in), .xport_in(xport_in),
		.fault_in(fault_in), .xfer_start_in(xfer_start_in), .host_run_in(run), .host_strobe_in(strobe),
		.host_data_in(hdata), .host_parity_in(parity), .loop_check_in(loop_check_in),
		.loop_loaded_in(loaded), .loop_readback_in(readback), .loop_step_in(step),
		.status_word_out(word), .status_valid_out(valid), .op_refused_out(refused),
		.data_invalid_out(invalid), .fatal_out(fatal));
	tfs_host_model u_host (.clk_in(mclk_in), .send_in(send), .bad_par_in(bad), .word_in(wd),
		.run_req_in(run_req), .strobe_out(strobe), .data_out(hdata), .parity_out(parity), .run_out(run));

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		@(posedge mclk_in);
		reg_wr_in <= 1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge mclk_in);
		reg_wr_in <= 0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge mclk_in);
		reg_rd_in <= 1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_rd_in <= 0;
		#1 d = rdata;
	endtask
	// waits a bounded time for the next report
	task automatic wt;
		#1;
		for (int n = 0; n < 20 && valid !== 1'b1; n++)
		begin
			@(posedge mclk_in);
			#1;
		end
	endtask
	task automatic op(input tfs_event_s ev, input tfs_xport_s x, input logic r, input logic [5:0] sub,
		input logic [5:0] code);
		@(posedge mclk_in);
		op_end_in <= 1;
		event_in <= ev;
		xport_in <= x;
		@(posedge mclk_in);
		op_end_in <= 0;
		wt;
		chk({valid, refused, invalid, word}, {1'b1, r, ev.rec_len_bad, sub, ev.xport_num, 2'b00, code});
	endtask
	// fault report, refusal while fatal, then formatter clear
	task automatic fend(input logic [5:0] sub);
		wt;
		chk({valid, word}, {1'b1, sub, 4'h0, 6'o30});
		chk(fatal, 1);
		op('0, ok, 1, 6'o02, 6'o11);
		wr(6'h00, 16'h4000);
		rd(6'h00);
		chk({fatal, d[0]}, 2'b00);
	endtask
	task automatic xfer;
		@(posedge mclk_in);
		xfer_start_in <= 1;
		@(posedge mclk_in);
		xfer_start_in <= 0;
	endtask

	initial
	begin
		#200000;
		errors++;
		test_done;
	end

	initial
	begin
		repeat (5) @(posedge mclk_in);
		reset_n_in <= 1;
		repeat (3) @(posedge mclk_in);
		ok = 6'b111100;
		e = '0;
		e.sense_updated = 1;
		e.xport_num = 2'h2;
		op(e, ok, 0, 6'o01, 6'o01);
		e = '0;
		op(e, ok, 0, 6'o00, 6'o01);
		e.end_mark_passed = 1;
		e.sense_updated = 1;
		op(e, ok, 0, 6'o01, 6'o04);
		e = '0;
		e.gain_burst = 1;
		op(e, ok, 0, 6'o00, 6'o02);
		e = '0;
		e.double_mark = 1;
		op(e, ok, 0, 6'o00, 6'o03);
		e = '0;
		e.start_mark_back = 1;
		op(e, ok, 0, 6'o00, 6'o03);
		e = '0;
		e.noop = 1;
		op(e, ok, 0, 6'o00, 6'o06);
		e = '0;
		e.rewind_start = 1;
		op(e, ok, 0, 6'o00, 6'o07);
		e = '0;
		e.write_op = 1;
		op(e, 6'b111101, 1, 6'o00, 6'o10);
		e = '0;
		op(e, 6'b111110, 1, 6'o00, 6'o11);
		op(e, 6'b111000, 1, 6'o01, 6'o11);
		op(e, 6'b110100, 1, 6'o00, 6'o12);
		op(e, 6'b101100, 1, 6'o00, 6'o13);
		op(e, 6'b000000, 1, 6'o00, 6'o14);
		for (int k = 1; k < 5; k++)
		begin
			e = '0;
			e.cap_fail = 3'(k);
			op(e, ok, 1, 6'(k), 6'o15);
		end
		for (int k = 0; k < 5; k++)
		begin
			e = '0;
			e.ecc_err = 1;
			e.ecc_fmt = tfs_ecc_fmt_e'(k);
			op(e, ok, 0, 6'(k + 1), 6'o27);
		end
		e = '0;
		e.ecc_fmt = ECC_WR_PE;
		e.wfail_cnt = 4'h1;
		op(e, ok, 0, 6'o06, 6'o27);
		e.ecc_fmt = ECC_WR_GCR;
		op(e, ok, 0, 6'o00, 6'o01);
		e.wfail_cnt = 4'h2;
		op(e, ok, 0, 6'o07, 6'o27);
		e = '0;
		e.rd_status_bad = 1;
		op(e, ok, 0, 6'o10, 6'o27);
		e = '0;
		e.crc_mism = 1;
		op(e, ok, 0, 6'o11, 6'o27);
		e = '0;
		e.rec_len_bad = 1;
		op(e, ok, 0, 6'o13, 6'o27);
		e = '0;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge mclk_in);
			send <= 1;
			wd <= 16'h1234;
			bad <= 1'(k);
			@(posedge mclk_in);
			send <= 0;
			op(e, ok, 0, k ? 6'o12 : 6'o00, k ? 6'o27 : 6'o01);
		end
		// the busy fault stands for a host that broke the ordering
		for (int k = 0; k < 5; k++)
		begin
			@(posedge mclk_in);
			fault_in <= 5'b10000 >> k;
			@(posedge mclk_in);
			fault_in <= '0;
			fend(6'(k < 3 ? k + 1 : k + 3));
		end
		rd(6'h08);
		chk(d, 16'h0000);
		wr(6'h08, 16'h2000);
		rd(6'h08);
		chk(d, 16'h2000);
		run_req <= 1;
		xfer;
		fend(6'o03);
		wr(6'h08, 16'h1000);
		run_req <= 0;
		xfer;
		fend(6'o04);
		// steps above the last one fold onto it
		for (int k = 0; k < 8; k++)
		begin
			@(posedge mclk_in);
			loop_check_in <= 1;
			loaded <= 8'h5a;
			readback <= 8'h5b;
			step <= 3'(k);
			@(posedge mclk_in);
			loop_check_in <= 0;
			fend(6'o10 + 6'(k > 5 ? 5 : k));
		end
		rd(6'h2c);
		chk(d, 16'h0809);
		rd(6'h3f);
		chk(d, 16'h0000);
		test_done;
	end
endmodule // tfs_status_gen_test

// >>> verilog/tfs_bus_parity.sv
// odd parity check of the host data bus, registered error pulse
// assumes data and parity valid while strobe is high
`timescale 1ns/1ps
module tfs_bus_parity #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             strobe_in,
	input  wire logic [WIDTH-1:0] data_in,
	input  wire logic             parity_in,
	output logic                  err_out
);
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			err_out <= 1'b0;
		else
			err_out <= strobe_in & ~(^{data_in, parity_in});
	end
endmodule // tfs_bus_parity

// >>> verilog/tfs_cmd_loopback.sv
// compares the command read back from the read microcontroller with the loaded one
// assumes the loaded command is held until the readback strobe
`timescale 1ns/1ps
module tfs_cmd_loopback #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             check_in,
	input  wire logic [WIDTH-1:0] loaded_in,
	input  wire logic [WIDTH-1:0] readback_in,
	input  wire logic [2:0]       step_in,
	output logic                  mismatch_out,
	output logic [2:0]            step_out
);
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mismatch_out <= 1'b0;
			step_out     <= 3'h0;
		end
		else
		begin
			mismatch_out <= check_in & (loaded_in != readback_in);
			// out-of-range steps fold onto the last one
			step_out     <= (step_in > 3'h5) ? 3'h5 : step_in;
		end
	end
endmodule // tfs_cmd_loopback

// >>> verilog/tfs_params.svh
// constants of the tape formatter status generator: offsets, fields, codes, times
// assumes inclusion by bare name from the package and the top module
`ifndef TFS_PARAMS_SVH
`define TFS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define TFS_OFS_HW_CTRL      6'h00
`define TFS_OFS_TAPE_CTRL    6'h08
`define TFS_OFS_STATUS       6'h2c
`define TFS_BIT_FMT_CLEAR    14
`define TFS_FMT_MSB          14
`define TFS_FMT_LSB          12
`define TFS_SKIP_MSB         11
`define TFS_SKIP_LSB         8
`define TFS_FMT_MAX          3'h1
`define TFS_TAPE_CTRL_RST    16'h0000
`define TFS_SUB_MSB          15
`define TFS_SUB_LSB          10
`define TFS_XP_MSB           9
`define TFS_XP_LSB           8
`define TFS_CODE_MSB         5
`define TFS_CODE_LSB         0

// ----------------------------------------------------------------
// interrupt codes (octal values)
// ----------------------------------------------------------------
`define TFS_IC_DONE          6'o01
`define TFS_IC_GAIN_BURST    6'o02
`define TFS_IC_START_MARK    6'o03
`define TFS_IC_LOGIC_END     6'o03
`define TFS_IC_END_MARK      6'o04
`define TFS_IC_NOOP          6'o06
`define TFS_IC_REWIND        6'o07
`define TFS_IC_WLOCK         6'o10
`define TFS_IC_NOT_READY     6'o11
`define TFS_IC_NOT_AVAIL     6'o12
`define TFS_IC_OFFLINE       6'o13
`define TFS_IC_NO_XPORT      6'o14
`define TFS_IC_NOT_CAPABLE   6'o15
`define TFS_IC_BAD_TAPE      6'o27
`define TFS_IC_FAULT         6'o30

// ----------------------------------------------------------------
// failure subcodes (octal values)
// ----------------------------------------------------------------
`define TFS_SC_NONE          6'o00
`define TFS_SC_SENSE         6'o01
`define TFS_SC_NR_ONLINE     6'o01
`define TFS_SC_NR_FATAL      6'o02
`define TFS_SC_WF_PE         6'o06
`define TFS_SC_WF_GCR        6'o07
`define TFS_SC_BAD_RD_STAT   6'o10
`define TFS_SC_CRC_MISM      6'o11
`define TFS_SC_BUS_PAR       6'o12
`define TFS_SC_REC_LEN       6'o13
`define TFS_SC_F_INV_CMD     6'o01
`define TFS_SC_F_XFER_BUSY   6'o02
`define TFS_SC_F_WR_CTL      6'o03
`define TFS_SC_F_NO_RUN      6'o04
`define TFS_SC_F_ECC_ROM     6'o06
`define TFS_SC_F_XFER_ROM    6'o07
`define TFS_SC_F_LOOP_BASE   6'o10
`define TFS_LOOP_STEP_MAX    3'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TFS_CLK_MHZ          50
`define TFS_RUN_WAIT_US      100

`endif

// >>> verilog/tfs_pkg.sv
// types of the tape formatter status generator
// assumes tfs_params.svh on the include path
package tfs_pkg;
	`include "tfs_params.svh"

	typedef enum logic [2:0] {ECC_WR_GCR, ECC_RD_GCR, ECC_RD_PE, ECC_WR_PE, ECC_OTHER} tfs_ecc_fmt_e;
	typedef enum logic {RUN_IDLE, RUN_WAIT} tfs_run_e;

	// selected transport condition
	typedef struct packed {
		logic       present;
		logic       online;
		logic       available;
		logic       ready;
		logic       busy_motion;
		logic       write_locked;
	} tfs_xport_s;

	// what happened in the ending operation
	typedef struct packed {
		logic        sense_updated;
		logic        start_mark_back;
		logic        end_mark_passed;
		logic        gain_burst;
		logic        double_mark;
		logic        noop;
		logic        rewind_start;
		logic        write_op;
		logic [2:0]  cap_fail;
		logic        ecc_err;
		tfs_ecc_fmt_e ecc_fmt;
		logic [3:0]  wfail_cnt;
		logic        rd_status_bad;
		logic        crc_mism;
		logic        rec_len_bad;
		logic [1:0]  xport_num;
	} tfs_event_s;

	// fault pulses reported as they occur
	typedef struct packed {
		logic       inv_cmd;
		logic       xfer_busy;
		logic       wr_ctl_err;
		logic       ecc_rom_pe;
		logic       xfer_rom_pe;
	} tfs_fault_s;
endpackage

// >>> verilog/tfs_status_gen.sv
// non-data status word generator of the tape formatter, with register port
// assumes synchronous inputs, one-cycle op_end and fault pulses from formatter logic
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tfs_params.svh"

module tfs_status_gen
	import tfs_pkg::*;
#(
	parameter int RUN_WAIT_CYC = `TFS_RUN_WAIT_US * `TFS_CLK_MHZ
) (
	input  wire logic         mclk_in,
	input  wire logic         reset_n_in,
	input  wire logic [5:0]   reg_addr_in,
	input  wire logic [15:0]  reg_wdata_in,
	input  wire logic         reg_wr_in,
	input  wire logic         reg_rd_in,
	output logic [15:0]       reg_rdata_out,
	input  wire logic         op_end_in,
	input  wire tfs_event_s   event_in,
	input  wire tfs_xport_s   xport_in,
	input  wire tfs_fault_s   fault_in,
	input  wire logic         xfer_start_in,
	input  wire logic         host_run_in,
	input  wire logic         host_strobe_in,
	input  wire logic [15:0]  host_data_in,
	input  wire logic         host_parity_in,
	input  wire logic         loop_check_in,
	input  wire logic [7:0]   loop_loaded_in,
	input  wire logic [7:0]   loop_readback_in,
	input  wire logic [2:0]   loop_step_in,
	output logic [15:0]       status_word_out,
	output logic              status_valid_out,
	output logic              op_refused_out,
	output logic              data_invalid_out,
	output logic              fatal_out
);
	import tfs_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic        rst_meta_ff;
	logic        rst_n_ff;

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [15:0] tape_ctrl_ff;
	logic        clear_pulse;
	logic        fmt_bad;

	assign clear_pulse = reg_wr_in && (reg_addr_in == `TFS_OFS_HW_CTRL) && reg_wdata_in[`TFS_BIT_FMT_CLEAR];

	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			tape_ctrl_ff <= `TFS_TAPE_CTRL_RST;
		else if (reg_wr_in && (reg_addr_in == `TFS_OFS_TAPE_CTRL))
			tape_ctrl_ff <= reg_wdata_in;
	end

	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			reg_rdata_out <= 16'h0000;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`TFS_OFS_HW_CTRL:   reg_rdata_out <= {15'h0000, fatal_out};
				`TFS_OFS_TAPE_CTRL: reg_rdata_out <= tape_ctrl_ff;
				`TFS_OFS_STATUS:    reg_rdata_out <= status_word_out;
				default:            reg_rdata_out <= 16'h0000;
			endcase
		end
		else
			reg_rdata_out <= 16'h0000;
	end

	// only normal and reversed packing exist; skip count takes any value
	// format check
	assign fmt_bad = tape_ctrl_ff[`TFS_FMT_MSB:`TFS_FMT_LSB] > `TFS_FMT_MAX;

	// ----------------------------------------------------------------
	// helpers: bus parity and command loopback
	// ----------------------------------------------------------------
	logic        par_err;
	logic        loop_mism;
	logic [2:0]  loop_step;

	tfs_bus_parity #(
		.WIDTH      (16)
	) u_parity (
		.clk_in     (mclk_in),
		.rst_n_in   (rst_n_ff),
		.strobe_in  (host_strobe_in),
		.data_in    (host_data_in),
		.parity_in  (host_parity_in),
		.err_out    (par_err)
	);

	tfs_cmd_loopback #(
		.WIDTH        (8)
	) u_loop (
		.clk_in       (mclk_in),
		.rst_n_in     (rst_n_ff),
		.check_in     (loop_check_in),
		.loaded_in    (loop_loaded_in),
		.readback_in  (loop_readback_in),
		.step_in      (loop_step_in),
		.mismatch_out (loop_mism),
		.step_out     (loop_step)
	);

	// sticky until the next ending operation, reported or not; a new error wins over the clear
	logic        par_seen_ff;

	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			par_seen_ff <= 1'b0;
		else if (par_err)
			par_seen_ff <= 1'b1;
		else if (op_end_in)
			par_seen_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// run signal watchdog
	// ----------------------------------------------------------------
	localparam int RW = $clog2(RUN_WAIT_CYC + 1);
	tfs_run_e    run_state_ff;
	logic [RW-1:0] run_cnt_ff;
	logic        run_timeout;

	assign run_timeout = (run_state_ff == RUN_WAIT) && !host_run_in && (run_cnt_ff == RW'(RUN_WAIT_CYC - 1));

	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			run_state_ff <= RUN_IDLE;
			run_cnt_ff   <= '0;
		end
		else
		begin
			unique case (run_state_ff)
				RUN_IDLE:
				begin
					run_cnt_ff <= '0;
					if (xfer_start_in && !host_run_in)
						run_state_ff <= RUN_WAIT;
				end
				RUN_WAIT:
				begin
					run_cnt_ff <= run_cnt_ff + 1'b1;
					if (host_run_in || run_timeout)
						run_state_ff <= RUN_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// fault selection, reported as soon as seen
	// ----------------------------------------------------------------
	logic        fault_hit;
	logic [5:0]  fault_sub;

	always_comb
	begin
		fault_hit = 1'b1;
		if (fault_in.inv_cmd)
			fault_sub = `TFS_SC_F_INV_CMD;
		else if (fault_in.xfer_busy)
			fault_sub = `TFS_SC_F_XFER_BUSY;
		else if (fault_in.wr_ctl_err || (xfer_start_in && fmt_bad))
			fault_sub = `TFS_SC_F_WR_CTL;
		else if (run_timeout)
			fault_sub = `TFS_SC_F_NO_RUN;
		else if (fault_in.ecc_rom_pe)
			fault_sub = `TFS_SC_F_ECC_ROM;
		else if (fault_in.xfer_rom_pe)
			fault_sub = `TFS_SC_F_XFER_ROM;
		else if (loop_mism)
			fault_sub = `TFS_SC_F_LOOP_BASE + {3'h0, loop_step};
		else
		begin
			fault_hit = 1'b0;
			fault_sub = `TFS_SC_NONE;
		end
	end

	// ----------------------------------------------------------------
	// operation end: code and subcode
	// ----------------------------------------------------------------
	logic [5:0]  end_code;
	logic [5:0]  end_sub;
	logic        end_refuse;
	logic        end_invalid;
	logic [5:0]  sense_sub;

	assign sense_sub = event_in.sense_updated ? `TFS_SC_SENSE : `TFS_SC_NONE;

	always_comb
	begin
		end_code    = `TFS_IC_DONE;
		end_sub     = sense_sub;
		end_refuse  = 1'b1;
		end_invalid = 1'b0;
		if (fatal_out)
		begin
			end_code = `TFS_IC_NOT_READY;
			end_sub  = `TFS_SC_NR_FATAL;
		end
		else if (!xport_in.present)
		begin
			end_code = `TFS_IC_NO_XPORT;
			end_sub  = `TFS_SC_NONE;
		end
		else if (!xport_in.online)
		begin
			end_code = `TFS_IC_OFFLINE;
			end_sub  = `TFS_SC_NONE;
		end
		else if (!xport_in.available)
		begin
			end_code = `TFS_IC_NOT_AVAIL;
			end_sub  = `TFS_SC_NONE;
		end
		else if (xport_in.busy_motion)
		begin
			end_code = `TFS_IC_NOT_READY;
			end_sub  = `TFS_SC_NONE;
		end
		else if (!xport_in.ready)
		begin
			end_code = `TFS_IC_NOT_READY;
			end_sub  = `TFS_SC_NR_ONLINE;
		end
		else if (event_in.write_op && xport_in.write_locked)
		begin
			end_code = `TFS_IC_WLOCK;
			end_sub  = `TFS_SC_NONE;
		end
		else if (event_in.cap_fail != 3'h0)
		begin
			end_code = `TFS_IC_NOT_CAPABLE;
			end_sub  = {3'h0, event_in.cap_fail};
		end
		else
		begin
			end_refuse = 1'b0;
			end_code   = `TFS_IC_BAD_TAPE;
			if (event_in.ecc_err)
				end_sub = {3'h0, event_in.ecc_fmt} + 6'h01;
			else if ((event_in.ecc_fmt == ECC_WR_PE) && (event_in.wfail_cnt != 4'h0))
				end_sub = `TFS_SC_WF_PE;
			else if ((event_in.ecc_fmt == ECC_WR_GCR) && (event_in.wfail_cnt > 4'h1))
				end_sub = `TFS_SC_WF_GCR;
			else if (event_in.rd_status_bad)
				end_sub = `TFS_SC_BAD_RD_STAT;
			else if (event_in.crc_mism)
				end_sub = `TFS_SC_CRC_MISM;
			else if (par_seen_ff || par_err)
				end_sub = `TFS_SC_BUS_PAR;
			else if (event_in.rec_len_bad)
			begin
				end_sub     = `TFS_SC_REC_LEN;
				end_invalid = 1'b1;
			end
			else if (event_in.rewind_start)
			begin
				end_code = `TFS_IC_REWIND;
				end_sub  = `TFS_SC_NONE;
			end
			else if (event_in.noop)
			begin
				end_code = `TFS_IC_NOOP;
				end_sub  = `TFS_SC_NONE;
			end
			else if (event_in.start_mark_back)
			begin
				end_code = `TFS_IC_START_MARK;
				end_sub  = `TFS_SC_NONE;
			end
			else if (event_in.double_mark)
			begin
				end_code = `TFS_IC_LOGIC_END;
				end_sub  = `TFS_SC_NONE;
			end
			else if (event_in.gain_burst)
			begin
				end_code = `TFS_IC_GAIN_BURST;
				end_sub  = `TFS_SC_NONE;
			end
			else if (event_in.end_mark_passed)
			begin
				end_code = `TFS_IC_END_MARK;
				end_sub  = sense_sub;
			end
			else
			begin
				end_code = `TFS_IC_DONE;
				end_sub  = sense_sub;
			end
		end
	end

	// ----------------------------------------------------------------
	// fatal state and status word
	// ----------------------------------------------------------------
	// fatal until clear; a fault in the clear cycle keeps it set
	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			fatal_out <= 1'b0;
		else if (fault_hit)
			fatal_out <= 1'b1;
		else if (clear_pulse)
			fatal_out <= 1'b0;
	end

	// faults take the word over an ending operation in the same cycle
	// word layout
	always_ff @(posedge mclk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			status_word_out  <= 16'h0000;
			status_valid_out <= 1'b0;
			op_refused_out   <= 1'b0;
			data_invalid_out <= 1'b0;
		end
		else
		begin
			status_valid_out <= fault_hit | op_end_in;
			op_refused_out   <= ~fault_hit & op_end_in & end_refuse;
			data_invalid_out <= ~fault_hit & op_end_in & end_invalid;
			if (fault_hit)
				status_word_out <= {fault_sub, event_in.xport_num, 2'b00, `TFS_IC_FAULT};
			else if (op_end_in)
				status_word_out <= {end_sub, event_in.xport_num, 2'b00, end_code};
		end
	end
endmodule // tfs_status_gen
